// ---- verilog/dpa_device_end.sv ----
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "dpa_defs.svh"
module dpa_device_end (
  input wire logic clock, // 40 MHz clock
  input wire logic resetn, // Async reset, active low
  dpa_link_if.dev link, // Primary access port
  input wire logic refreshRequest, // Refresh wanted, level
  input wire logic secondaryActive, // Secondary port access running
  input wire logic secondary_port_grant, // Secondary port holds the grant
  output logic [`DPA_BANKS-1:0] rasN, // Row strobes, active low
  output logic [`DPA_BANKS-1:0] casN, // Column strobes, active low
  output logic [`DPA_ROW_W-1:0] dramAddr, // Multiplexed DRAM address
  output logic weN // Write enable or refresh request
);
  import dpa_pkg::*;
  localparam logic [`DPA_CNT_W-1:0] COL_HOLD = `DPA_CNT_W'(`DPA_COL_HOLD_CYC);

  dpa_dev_s r;
  dpa_dev_s next_r;
  logic transp;
  logic startSync;
  logic startAsync;
  logic startReq;
  logic blocked;
  logic asyncDirect;
  logic accessing;
  logic refreshing;
  logic [`DPA_ROW_W-1:0] effRow;
  logic [`DPA_COL_W-1:0] effCol;
  logic [`DPA_BANK_W-1:0] effBank;
  logic [`DPA_CNT_W-1:0] preCount;
  logic [`DPA_CNT_W-1:0] refLow;
  logic [1:0] grantLat;

  // =====================================
  // Timing choices from refresh timing bits
  always_comb begin
    unique case (r.refTiming)
      2'b00: begin
        preCount = 3'h1;
        refLow = 3'h2;
      end
      2'b01: begin
        preCount = 3'h2;
        refLow = 3'h3;
      end
      2'b10: begin
        preCount = 3'h2;
        refLow = 3'h2;
      end
      2'b11: begin
        preCount = 3'h3;
        refLow = 3'h4;
      end
    endcase
    grantLat = r.refTiming[0] ? 2'h2 : 2'h1;
  end

  // =====================================
  // Start detection and address path
  assign startSync = !r.accessMode && link.latchEnable && !link.chipSelectN;
  assign startAsync = r.accessMode && r.armed && !link.address_strobe_n
                      && !link.chipSelectN;
  assign startReq = startSync || startAsync || r.pend;
  // Mode 0 follows enable; mode 1 transparent while idle until strobe falls
  assign transp = r.accessMode ? ((link.address_strobe_n && r.state == DPA_IDLE) || startAsync)
                               : link.latchEnable;
  assign effRow = (!r.latchMode || transp) ? link.rowAddr : r.latRow;
  assign effCol = (!r.latchMode || transp) ? link.colAddr : r.latCol;
  assign effBank = (!r.latchMode || transp) ? link.bankAddr : r.latBank;
  assign blocked = refreshRequest || secondaryActive || secondary_port_grant
                   || r.pre[effBank] != 3'h0;
  assign accessing = r.state == DPA_ACTIVE || r.state == DPA_HOLD;
  assign refreshing = r.state == DPA_REFRUN;
  assign asyncDirect = r.state == DPA_IDLE && startAsync && !blocked;

  // =====================================
  // Access sequencer
  always_comb begin
    next_r = r;
    if (link.progLoad) begin
      next_r.accessMode = link.access_mode_bit;
      next_r.latchMode = link.latch_mode_bit;
      next_r.pipeSel = link.pipeline_select_bit;
      next_r.refTiming = {link.refresh_timing_bit_hi, link.refresh_timing_bit_lo};
      next_r.waitEn = link.waitEnable;
    end
    for (int i = 0; i < `DPA_BANKS; i++) begin
      if (r.pre[i] != 3'h0) begin
        next_r.pre[i] = r.pre[i] - 3'h1;
      end
    end
    if (link.address_strobe_n) begin
      next_r.armed = 1'b1;
    end
    if (r.latchMode && transp) begin
      next_r.latRow = link.rowAddr;
      next_r.latCol = link.colAddr;
      next_r.latBank = link.bankAddr;
    end else if (r.latchMode && accessing && link.column_step
                 && link.refresh_active_n) begin
      next_r.latCol = r.latCol + `DPA_COL_W'(1);
    end
    if (r.colHold != 3'h0) begin
      next_r.colHold = r.colHold - 3'h1;
    end
    unique case (r.state)
      DPA_IDLE: begin
        if (refreshRequest && r.pre == '0) begin
          next_r.state = DPA_REFSET;
        end else if (startReq) begin
          next_r.armed = r.armed && !startAsync;
          next_r.pend = 1'b0;
          next_r.bank = effBank;
          next_r.state = blocked ? DPA_WAITS : DPA_ACTIVE;
        end
      end
      DPA_WAITS: begin
        if (secondary_port_grant) begin
          next_r.grantCnt = grantLat;
        end else if (r.grantCnt != 2'h0) begin
          next_r.grantCnt = r.grantCnt - 2'h1;
          if (r.grantCnt == 2'h1) begin
            next_r.latRow = link.rowAddr;
            next_r.latCol = link.colAddr;
            next_r.latBank = link.bankAddr;
            next_r.bank = link.bankAddr;
          end
        end else if (!refreshRequest && !secondaryActive
                     && r.pre[r.bank] == 3'h0) begin
          next_r.state = DPA_ACTIVE;
        end else if (refreshRequest && r.pre == '0) begin
          next_r.state = DPA_REFSET;
        end
      end
      DPA_ACTIVE: begin
        next_r.state = DPA_HOLD;
        next_r.colHold = COL_HOLD;
      end
      DPA_HOLD: begin
        if (!r.pipeSel && (startSync || startAsync)) begin
          next_r.pend = 1'b1;
          next_r.armed = r.armed && !startAsync;
        end
        if (link.access_hold_request_n) begin
          next_r.state = DPA_IDLE;
          next_r.pre[r.bank] = preCount;
        end
      end
      DPA_REFSET: begin
        next_r.state = DPA_REFRUN;
        next_r.refCnt = refLow;
      end
      DPA_REFRUN: begin
        if (link.column_step) begin
          next_r.refCnt = r.refCnt;
        end else if (r.refCnt <= 3'h1) begin
          next_r.state = DPA_IDLE;
          for (int i = 0; i < `DPA_BANKS; i++) begin
            next_r.pre[i] = preCount;
          end
        end else begin
          next_r.refCnt = r.refCnt - 3'h1;
        end
      end
      default: begin
        next_r.state = DPA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '{state: DPA_IDLE, pipeSel: 1'b1, armed: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // =====================================
  // DRAM and handshake outputs
  always_comb begin
    for (int i = 0; i < `DPA_BANKS; i++) begin
      rasN[i] = !((accessing && r.bank == i) || refreshing
                  || (asyncDirect && effBank == i));
      casN[i] = !(r.state == DPA_HOLD && !link.cas_enable_n[i]);
    end
    if (r.state == DPA_HOLD && !(!r.pipeSel && r.colHold == 3'h0)) begin
      dramAddr = effCol;
    end else if (accessing) begin
      dramAddr = r.latchMode ? r.latRow : link.rowAddr;
    end else begin
      dramAddr = effRow;
    end
    if (!r.pipeSel) begin
      weN = !refreshRequest;
    end else begin
      weN = !(accessing && !link.write_request_n);
    end
  end

  // Ack drops combinationally once hold request is released
  assign link.transfer_ack_n = !(r.state == DPA_HOLD
                                 && !link.access_hold_request_n);
  assign link.waitN = !(r.waitEn && (r.state == DPA_WAITS || r.state == DPA_ACTIVE
                        || r.pend || (startReq && r.state != DPA_HOLD)));
  assign link.refresh_active_n = !(r.state == DPA_REFSET || refreshing);
endmodule

// ---- verilog/dpa_defs.svh ----
`ifndef DPA_DEFS_SVH
`define DPA_DEFS_SVH

// Widths
`define DPA_ROW_W 10
`define DPA_COL_W 10
`define DPA_BANK_W 2
`define DPA_BANKS 4
`define DPA_CNT_W 3

// Timing
`define DPA_CLK_PERIOD_NS 25
`define DPA_COL_HOLD_NS 15
`define DPA_COL_HOLD_CYC ((`DPA_COL_HOLD_NS + `DPA_CLK_PERIOD_NS - 1) / `DPA_CLK_PERIOD_NS)

// Host register offsets
`define DPA_REG_CFG 4'h0
`define DPA_REG_ADDR 4'h4
`define DPA_REG_HOLD 4'h8
`define DPA_REG_CMD 4'hC
`define DPA_REG_STATUS 4'h0
`define DPA_REG_STATUS_IDX 4'h0

// Configuration field positions and reset values
`define DPA_CFG_MODE 0
`define DPA_CFG_LATCH 1
`define DPA_CFG_PIPE 2
`define DPA_CFG_RT_LO 3
`define DPA_CFG_RT_HI 4
`define DPA_CFG_WAIT 5
`define DPA_CFG_RESET 6'h04
`define DPA_HOLD_RESET 8'h04
`endif

// ---- verilog/dpa_pkg.sv ----
`include "dpa_defs.svh"
package dpa_pkg;
  typedef enum logic [2:0] {
    DPA_IDLE = 3'b000,
    DPA_WAITS = 3'b001,
    DPA_ACTIVE = 3'b010,
    DPA_HOLD = 3'b011,
    DPA_REFSET = 3'b100,
    DPA_REFRUN = 3'b101
  } dpa_dev_e;

  typedef enum logic [2:0] {
    DPAH_IDLE = 3'b000,
    DPAH_START = 3'b001,
    DPAH_REQ = 3'b010,
    DPAH_HOLD = 3'b011,
    DPAH_GAP = 3'b100
  } dpa_host_e;

  typedef struct packed {
    dpa_dev_e state;
    logic accessMode;
    logic latchMode;
    logic pipeSel;
    logic [1:0] refTiming;
    logic waitEn;
    logic armed;
    logic pend;
    logic [`DPA_BANK_W-1:0] bank;
    logic [`DPA_ROW_W-1:0] latRow;
    logic [`DPA_COL_W-1:0] latCol;
    logic [`DPA_BANK_W-1:0] latBank;
    logic [`DPA_CNT_W-1:0] colHold;
    logic [`DPA_CNT_W-1:0] refCnt;
    logic [1:0] grantCnt;
    logic [`DPA_BANKS-1:0][`DPA_CNT_W-1:0] pre;
  } dpa_dev_s;

  typedef struct packed {
    dpa_host_e state;
    logic [5:0] cfg;
    logic [22:0] addr;
    logic [7:0] holdLen;
    logic [7:0] holdCnt;
    logic [15:0] doneCount;
    logic progLoad;
    logic stepReq;
    logic [31:0] rdData;
  } dpa_host_s;
endpackage

// ---- verilog/dpa_link_if.sv ----
`timescale 1ns/1ps
`include "dpa_defs.svh"
interface dpa_link_if;
  logic progLoad;
  logic access_mode_bit;
  logic latch_mode_bit;
  logic pipeline_select_bit;
  logic refresh_timing_bit_lo;
  logic refresh_timing_bit_hi;
  logic waitEnable;
  logic latchEnable;
  logic address_strobe_n;
  logic chipSelectN;
  logic access_hold_request_n;
  logic column_step;
  logic [3:0] cas_enable_n;
  logic write_request_n;
  logic [`DPA_ROW_W-1:0] rowAddr;
  logic [`DPA_COL_W-1:0] colAddr;
  logic [`DPA_BANK_W-1:0] bankAddr;
  logic transfer_ack_n;
  logic waitN;
  logic refresh_active_n;

  modport dev(
    input progLoad, access_mode_bit, latch_mode_bit, pipeline_select_bit,
    input refresh_timing_bit_lo, refresh_timing_bit_hi, waitEnable,
    input latchEnable, address_strobe_n, chipSelectN, access_hold_request_n,
    input column_step, cas_enable_n, write_request_n, rowAddr, colAddr, bankAddr,
    output transfer_ack_n, waitN, refresh_active_n
  );
  modport host(
    output progLoad, access_mode_bit, latch_mode_bit, pipeline_select_bit,
    output refresh_timing_bit_lo, refresh_timing_bit_hi, waitEnable,
    output latchEnable, address_strobe_n, chipSelectN, access_hold_request_n,
    output column_step, cas_enable_n, write_request_n, rowAddr, colAddr, bankAddr,
    input transfer_ack_n, waitN, refresh_active_n
  );
endinterface

// ---- verilog/dpa_host_end.sv ----
`timescale 1ns/1ps
`include "dpa_defs.svh"
module dpa_host_end (
  input wire logic clock, // 40 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic [3:0] regAddr, // Register byte address
  input wire logic [31:0] regWrData, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [31:0] regRdData, // Read data, cycle after strobe
  dpa_link_if.host link // Controller side of the port
);
  import dpa_pkg::*;
  dpa_host_s r;
  dpa_host_s next_r;
  logic cmdStart;
  logic mode1;

  // =====================================
  // Sequencer
  always_comb begin
    next_r = r;
    next_r.progLoad = 1'b0;
    next_r.rdData = 32'h0;
    cmdStart = regWrite && regAddr == `DPA_REG_CMD && regWrData[0];
    mode1 = r.cfg[`DPA_CFG_MODE];
    if (regWrite && regAddr == `DPA_REG_CFG) begin
      next_r.cfg = regWrData[5:0];
      next_r.progLoad = 1'b1;
    end
    if (regWrite && regAddr == `DPA_REG_ADDR && r.state == DPAH_IDLE) begin
      next_r.addr = regWrData[22:0];
    end
    if (regWrite && regAddr == `DPA_REG_HOLD) begin
      next_r.holdLen = regWrData[7:0];
    end
    // Step request stays pending until issued during hold
    if (link.column_step) begin
      next_r.stepReq = 1'b0;
    end
    if (regWrite && regAddr == `DPA_REG_CMD && regWrData[1]) begin
      next_r.stepReq = 1'b1;
    end
    if (regRead && regAddr == `DPA_REG_STATUS) begin
      next_r.rdData = {13'h0000, r.state, r.doneCount};
    end
    unique case (r.state)
      DPAH_IDLE: begin
        if (cmdStart) begin
          next_r.state = DPAH_START;
        end
      end
      DPAH_START: begin
        next_r.state = DPAH_REQ;
      end
      DPAH_REQ: begin
        if (!link.transfer_ack_n) begin
          next_r.state = DPAH_HOLD;
          next_r.holdCnt = r.holdLen;
        end
      end
      DPAH_HOLD: begin
        if (r.holdCnt == 8'h00) begin
          next_r.state = DPAH_GAP;
          next_r.doneCount = r.doneCount + 16'h0001;
        end else begin
          next_r.holdCnt = r.holdCnt - 8'h01;
        end
      end
      DPAH_GAP: begin
        next_r.state = DPAH_IDLE;
      end
      default: begin
        next_r.state = DPAH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '{state: DPAH_IDLE, cfg: `DPA_CFG_RESET, holdLen: `DPA_HOLD_RESET,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // =====================================
  // Link drive
  assign regRdData = r.rdData;
  assign link.progLoad = r.progLoad;
  assign link.access_mode_bit = r.cfg[`DPA_CFG_MODE];
  assign link.latch_mode_bit = r.cfg[`DPA_CFG_LATCH];
  assign link.pipeline_select_bit = r.cfg[`DPA_CFG_PIPE];
  assign link.refresh_timing_bit_lo = r.cfg[`DPA_CFG_RT_LO];
  assign link.refresh_timing_bit_hi = r.cfg[`DPA_CFG_RT_HI];
  assign link.waitEnable = r.cfg[`DPA_CFG_WAIT];
  assign link.latchEnable = !mode1 && r.state == DPAH_START;
  assign link.address_strobe_n = !(mode1 && r.state == DPAH_START);
  assign link.chipSelectN = !(r.state == DPAH_START);
  assign link.access_hold_request_n = !(r.state == DPAH_REQ || r.state == DPAH_HOLD);
  assign link.column_step = r.stepReq && link.refresh_active_n && r.state == DPAH_HOLD;
  // Write request only changes while CAS is disabled
  assign link.cas_enable_n = (r.state == DPAH_HOLD) ? 4'h0 : 4'hF;
  assign link.write_request_n = !r.addr[22];
  assign link.rowAddr = r.addr[9:0];
  assign link.colAddr = r.addr[19:10];
  assign link.bankAddr = r.addr[21:20];
endmodule

// ---- verif/dpa_link_sva.sv ----
`timescale 1ns/1ps
`include "dpa_defs.svh"
module dpa_link_sva (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic progLoad, // Config load
  input wire logic pipeline_select_bit, // Pipeline bit
  input wire logic latchEnable, // Sync start
  input wire logic access_hold_request_n, // Hold request
  input wire logic column_step, // Column step
  input wire logic write_request_n, // Write request
  input wire logic transfer_ack_n, // Acknowledge
  input wire logic refresh_active_n, // Refresh running
  input wire logic [`DPA_BANKS-1:0] rasN, // Row strobes
  input wire logic [`DPA_BANKS-1:0] casN, // Column strobes
  input wire logic weN, // Write enable
  input wire logic refreshRequest, // Refresh wanted
  input wire logic secondaryActive // Secondary busy
);
  logic pipeOff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ====
  // Loaded pipeline choice
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pipeOff <= 1'b1;
    end else if (progLoad) begin
      pipeOff <= pipeline_select_bit;
    end
  end
  // ====
  // Checks
  ack_needs_hold_a: assert property (!transfer_ack_n |-> !access_hold_request_n)
    else $error("ack low without hold request");
  ack_needs_ras_a: assert property (!transfer_ack_n |-> rasN != 4'hF)
    else $error("ack low without row strobe");
  refresh_no_ack_a: assert property (!refresh_active_n |-> transfer_ack_n)
    else $error("ack during refresh");
  block_no_start_a: assert property (secondaryActive && $past(secondaryActive) && $past(&rasN)
    && refresh_active_n |-> &rasN)
    else $error("start while secondary busy");
  step_extends_a: assert property (!refresh_active_n && rasN == 4'h0 && column_step
    |=> !refresh_active_n)
    else $error("refresh not extended");
  hold_after_start_a: assert property (pipeOff && $rose(latchEnable) |-> access_hold_request_n)
    else $error("hold request with start");
  le_by_release_a: assert property ($rose(access_hold_request_n) |-> !latchEnable)
    else $error("latch enable high at release");
  pipe_start_gap_a: assert property (!pipeOff && $rose(latchEnable) && !access_hold_request_n
    |-> !$past(access_hold_request_n))
    else $error("pipelined start too early");
  we_is_refresh_a: assert property (!pipeOff |-> weN == !refreshRequest)
    else $error("write enable not refresh request");
  win_cas_off_a: assert property ($changed(write_request_n) |-> &casN)
    else $error("write request changed with CAS on");
  cover property (!transfer_ack_n && pipeOff);
  cover property (!transfer_ack_n && !pipeOff);
  cover property ($fell(refresh_active_n));
  cover property (secondaryActive && $past(secondaryActive));
endmodule

// ---- verif/dram_primary_port_access_tb.sv ----
`timescale 1ns/1ps
`include "dpa_defs.svh"
module dram_primary_port_access_tb;
  import dpa_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic refreshRequest = 1'b0;
  logic secondaryActive = 1'b0;
  logic secondaryGrant = 1'b0;
  logic [3:0] rasN;
  logic [3:0] casN;
  logic [9:0] dramAddr;
  logic weN;
  int num_errors = 0;
  int n_tests = 0;
  int seed = 32'h016b;
  int ackIdx = 0;
  int refCycles = 0;
  logic chk = 1'b0;
  logic blk = 1'b0;
  logic expMode = 1'b0;
  logic expPipe = 1'b0;
  logic expWait = 1'b0;
  logic prevStart = 1'b0;
  logic startNow;
  logic [9:0] expRow = 10'h0;
  logic [9:0] expCol = 10'h0;
  logic [9:0] lastCol = 10'h0;
  logic [1:0] expBank = 2'h0;
  logic [3:0] prevRas = 4'hF;
  dpa_link_if link();
  dpa_host_end u_dpa_host_end (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .link(link));
  dpa_device_end u_dpa_device_end (.clock(clock), .resetn(resetn), .link(link),
    .refreshRequest(refreshRequest), .secondaryActive(secondaryActive),
    .secondary_port_grant(secondaryGrant), .rasN(rasN), .casN(casN), .dramAddr(dramAddr),
    .weN(weN));
  dpa_link_sva u_dpa_link_sva (.clock(clock), .resetn(resetn), .progLoad(link.progLoad),
    .pipeline_select_bit(link.pipeline_select_bit), .latchEnable(link.latchEnable),
    .access_hold_request_n(link.access_hold_request_n), .column_step(link.column_step),
    .write_request_n(link.write_request_n), .transfer_ack_n(link.transfer_ack_n),
    .refresh_active_n(link.refresh_active_n), .rasN(rasN), .casN(casN), .weN(weN),
    .refreshRequest(refreshRequest), .secondaryActive(secondaryActive));
  assign startNow = !link.chipSelectN && (expMode ? !link.address_strobe_n : link.latchEnable);
  initial begin
    forever #12.5 clock = ~clock;
  end
  // ====
  // Shared tasks
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_tests++;
    if (e !== s) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    d = regRdData;
  endtask
  function automatic logic [15:0] exp_col(input logic [9:0] c, input logic step);
    logic [9:0] n;
    n = c + {9'h0, step};
    return {6'h0, n};
  endfunction
  task automatic tally_and_finish();
    if (num_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ====
  // Port monitor
  always @(posedge clock) begin
    if (chk && startNow && !prevStart) begin
      cmp("startWait", {15'h0, !expWait}, {15'h0, link.waitN});
      if (!blk) begin
        cmp("startRas", {15'h0, !expMode}, {15'h0, rasN[expBank]});
      end
    end
    if (chk && prevRas[expBank] && !rasN[expBank] && link.refresh_active_n) begin
      cmp("rowAddr", {6'h0, expRow}, {6'h0, dramAddr});
    end
    if (!link.refresh_active_n) begin
      refCycles++;
    end
    if (chk && !link.transfer_ack_n) begin
      if (ackIdx == 0) begin
        cmp("colAddr", {6'h0, expCol}, {6'h0, dramAddr});
      end
      if (expPipe && ackIdx >= 2) begin
        cmp("pipeRow", {6'h0, expRow}, {6'h0, dramAddr});
      end
      lastCol = dramAddr;
      ackIdx++;
    end else begin
      ackIdx = 0;
    end
    prevRas = rasN;
    prevStart = startNow;
  end
  // ====
  // One access through the host end
  task automatic run_access(input int kind, input logic [5:0] cfg, input logic [9:0] c,
    input logic st);
    logic [31:0] d0;
    logic [31:0] d;
    logic [31:0] rnd;
    int n;
    rnd = $random(seed);
    wr(`DPA_REG_CFG, {26'h0, cfg});
    wr(`DPA_REG_ADDR, {9'h0, rnd[12], rnd[11:10], c, rnd[9:0]});
    rd(`DPA_REG_STATUS, d0);
    expRow = rnd[9:0];
    expCol = c;
    expBank = rnd[11:10];
    expMode = cfg[0];
    expPipe = !cfg[2];
    expWait = cfg[5];
    blk = (kind > 1);
    chk = 1'b1;
    secondaryActive <= (kind == 2);
    secondaryGrant <= (kind == 3);
    wr(`DPA_REG_CMD, {30'h0, st, 1'b1});
    repeat (6) @(posedge clock);
    secondaryActive <= 1'b0;
    secondaryGrant <= 1'b0;
    d = d0;
    n = 0;
    while (d[15:0] === d0[15:0] && n < 100) begin
      rd(`DPA_REG_STATUS, d);
      n++;
    end
    chk = 1'b0;
    cmp("doneCount", d0[15:0] + 16'h1, d[15:0]);
    if (!expPipe) begin
      cmp("holdCol", exp_col(c, st & cfg[1]), {6'h0, lastCol});
    end
  endtask
  // ====
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [31:0] rnd;
    logic [9:0] c;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    rd(`DPA_REG_STATUS, d);
    cmp("status", 16'h0, d[15:0]);
    rd(4'h2, d);
    cmp("unmapped", 16'h0, d[15:0]);
    wr(`DPA_REG_HOLD, 32'h5);
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      c = (i == 3) ? 10'h3FF : rnd[13:4];
      run_access(i / 4, {rnd[2:0], i / 4 != 1, i[1], i[0]}, c, i[1]);
    end
    wr(`DPA_REG_CFG, 32'h0);
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      rnd = $random(seed);
      refreshRequest <= rnd[0];
    end
    @(posedge clock);
    refreshRequest <= 1'b0;
    cmp("refreshSeen", 16'h1, {15'h0, refCycles != 0});
    tally_and_finish();
  end
  initial begin
    #(25 * 40000);
    num_errors++;
    tally_and_finish();
  end
endmodule
